/* File: logic/ptcc_pkg.sv */
package ptcc_pkg;

   // Register byte addresses, one aligned word each
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CMPA_LO = 8'h08;
   localparam logic [7:0] OFS_CMPA_HI = 8'h0C;
   localparam logic [7:0] OFS_PER_LO = 8'h10;
   localparam logic [7:0] OFS_PER_HI = 8'h14;
   localparam logic [7:0] OFS_CNT_LO = 8'h18;
   localparam logic [7:0] OFS_CNT_HI = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   // Status register bit positions
   localparam int unsigned STAT_FLAG_A = 0;
   localparam int unsigned STAT_FLAG_P = 1;
   localparam int unsigned STAT_PIN = 2;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // Timer clock selections
   localparam logic [2:0] CKSEL_SYS4 = 3'h0;
   localparam logic [2:0] CKSEL_EXT_FALL = 3'h7;

   // Default slow sub-clock divide ratio
   localparam int unsigned SUB_DIV_DEF = 256;

   typedef enum logic [1:0] {
      PTCC_MODE_CMP = 2'b00,
      PTCC_MODE_CAP = 2'b01,
      PTCC_MODE_PWM = 2'b10,
      PTCC_MODE_TC = 2'b11
   } ptcc_mode_e;

   // Pin action codes (meaning depends on mode)
   localparam logic [1:0] ACT_00 = 2'b00;
   localparam logic [1:0] ACT_01 = 2'b01;
   localparam logic [1:0] ACT_10 = 2'b10;
   localparam logic [1:0] ACT_11 = 2'b11;

   // Control 0: bit 7 pause, bits 6:4 clock select, bit 3 run
   typedef struct packed {
      logic pause;
      logic [2:0] clk_sel;
      logic run_bit;
      logic [2:0] unused;
   } ptcc_ctrl0_s;

   // Control 1: mode, pin action, initial level, invert, capture source, clear select
   typedef struct packed {
      ptcc_mode_e op_mode_select;
      logic [1:0] pin_action_select;
      logic output_initial_level;
      logic output_invert;
      logic capture_source_select;
      logic counter_clear_select;
   } ptcc_ctrl1_s;

endpackage

/* File: logic/ptcc_timer.sv */
`timescale 1ns/1ps
module ptcc_timer #(
   parameter int unsigned SUB_DIV = ptcc_pkg::SUB_DIV_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clock_pin,
   input wire logic capture_input_pin,
   output logic timer_out,
   output logic timer_out_en
);

   if (SUB_DIV < 2) begin : g_bad_div
      $error("SUB_DIV must be at least 2");
   end

   localparam int unsigned SUB_W = $clog2(SUB_DIV);

   ptcc_pkg::ptcc_ctrl0_s ctrl0;
   ptcc_pkg::ptcc_ctrl1_s ctrl1;
   logic [15:0] compare_a_value;
   logic [15:0] period_compare_value;
   logic [15:0] cnt;
   logic compare_a_flag;
   logic compare_p_flag;
   logic run_prev;
   logic cmp_lvl;
   logic cap_pend;
   logic [5:0] div_cnt;
   logic [SUB_W-1:0] sub_cnt;
   logic ext_meta, ext_sync, ext_last;
   logic cap_meta, cap_sync, cap_last;

   // Bus decode
   wire setup = psel & ~penable;
   wire wr_ok = psel & penable & pready & pwrite & ~pslverr;
   wire sel_c0 = paddr == ptcc_pkg::OFS_CTRL0;
   wire sel_c1 = paddr == ptcc_pkg::OFS_CTRL1;
   wire sel_al = paddr == ptcc_pkg::OFS_CMPA_LO;
   wire sel_ah = paddr == ptcc_pkg::OFS_CMPA_HI;
   wire sel_pl = paddr == ptcc_pkg::OFS_PER_LO;
   wire sel_ph = paddr == ptcc_pkg::OFS_PER_HI;
   wire sel_nl = paddr == ptcc_pkg::OFS_CNT_LO;
   wire sel_nh = paddr == ptcc_pkg::OFS_CNT_HI;
   wire sel_st = paddr == ptcc_pkg::OFS_STATUS;
   wire mapped = sel_c0 | sel_c1 | sel_al | sel_ah | sel_pl | sel_ph | sel_nl | sel_nh | sel_st;
   wire wr_c0 = wr_ok & sel_c0;
   wire wr_st = wr_ok & sel_st;
   wire [7:0] wbyte = pwdata[7:0];
   wire [7:0] status = {5'h00, timer_out, compare_p_flag, compare_a_flag};
   wire [7:0] rd_byte = sel_c0 ? ctrl0 :
                        sel_c1 ? ctrl1 :
                        sel_al ? compare_a_value[7:0] :
                        sel_ah ? compare_a_value[15:8] :
                        sel_pl ? period_compare_value[7:0] :
                        sel_ph ? period_compare_value[15:8] :
                        sel_nl ? cnt[7:0] :
                        sel_nh ? cnt[15:8] :
                        sel_st ? status : 8'h00;

   // Mode decode
   wire [1:0] act = ctrl1.pin_action_select;
   wire mode_cap = ctrl1.op_mode_select == ptcc_pkg::PTCC_MODE_CAP;
   wire mode_pwm = ctrl1.op_mode_select == ptcc_pkg::PTCC_MODE_PWM;
   wire mode_tc = ctrl1.op_mode_select == ptcc_pkg::PTCC_MODE_TC;
   wire mode_cmp = (ctrl1.op_mode_select == ptcc_pkg::PTCC_MODE_CMP) | mode_tc;
   wire single = mode_pwm & (act == ptcc_pkg::ACT_11);
   wire clr_on_a = mode_cmp & ctrl1.counter_clear_select;

   // Timer clock enables
   wire tick_4 = div_cnt[1:0] == 2'h3;
   wire tick_16 = div_cnt[3:0] == 4'hF;
   wire tick_64 = div_cnt == 6'h3F;
   wire sub_tick = sub_cnt == SUB_W'(SUB_DIV - 1);
   wire ext_rise = ext_sync & ~ext_last;
   wire ext_fall = ~ext_sync & ext_last;
   wire [7:0] tick_src = {ext_fall, ext_rise, sub_tick, sub_tick, tick_64, tick_16, 1'b1, tick_4};
   wire tick = tick_src[ctrl0.clk_sel];
   wire ext_active = (ctrl0.clk_sel == ptcc_pkg::CKSEL_EXT_FALL) ? ext_fall : ext_rise;

   // Counter and comparators
   wire run_rise = ctrl0.run_bit & ~run_prev;
   wire counting = ctrl0.run_bit & ~ctrl0.pause & tick;
   wire [15:0] cnt_inc = 16'(cnt + 16'h0001);
   wire [15:0] per_last = 16'(period_compare_value - 16'h0001);
   wire a_eq = (cnt_inc == compare_a_value) & (compare_a_value != 16'h0000);
   wire p_eq = cnt == per_last;
   wire a_hit = counting & a_eq & ~mode_cap;
   wire p_hit = counting & p_eq & ~single & ~clr_on_a;
   wire clear_now = clr_on_a ? a_hit : p_hit;
   wire [15:0] next_cnt = run_rise ? 16'h0000 :
                          ~counting ? cnt :
                          clear_now ? 16'h0000 : cnt_inc;

   // Run bit: software write beats hardware clear beats hardware set
   wire hw_run_clr = single & a_hit;
   wire hw_run_set = single & ext_active & ~ctrl0.run_bit;
   wire next_run = wr_c0 ? wbyte[3] :
                   hw_run_clr ? 1'b0 :
                   hw_run_set ? 1'b1 : ctrl0.run_bit;

   // Capture
   wire cap_sig = ctrl1.capture_source_select ? ext_sync : cap_sync;
   wire cap_last_sel = ctrl1.capture_source_select ? ext_last : cap_last;
   wire cap_r = cap_sig & ~cap_last_sel;
   wire cap_f = ~cap_sig & cap_last_sel;
   wire cap_edge = (act == ptcc_pkg::ACT_00) ? cap_r :
                   (act == ptcc_pkg::ACT_01) ? cap_f :
                   (act == ptcc_pkg::ACT_10) ? (cap_r | cap_f) : 1'b0;
   wire cap_fire = mode_cap & ctrl0.run_bit & cap_edge;
   wire cap_flag_set = cap_pend & tick;

   // Flags, set wins over write-one-to-clear
   wire set_a = a_hit | cap_flag_set;
   wire set_p = p_hit;
   wire next_flag_a = set_a | (compare_a_flag & ~(wr_st & wbyte[ptcc_pkg::STAT_FLAG_A]));
   wire next_flag_p = set_p | (compare_p_flag & ~(wr_st & wbyte[ptcc_pkg::STAT_FLAG_P]));

   // Compare-mode pin level before inversion
   wire next_cmp_lvl = run_rise ? ctrl1.output_initial_level :
                       ~a_hit ? cmp_lvl :
                       (act == ptcc_pkg::ACT_01) ? 1'b0 :
                       (act == ptcc_pkg::ACT_10) ? 1'b1 :
                       (act == ptcc_pkg::ACT_11) ? ~cmp_lvl : cmp_lvl;

   // PWM waveform; 17-bit period so zero reads as 65536
   wire [16:0] per17 = (period_compare_value == 16'h0000) ? 17'h10000 :
                       {1'b0, period_compare_value};
   wire [16:0] a17 = {1'b0, compare_a_value};
   wire pwm_on = (a17 > {1'b0, cnt}) | (a17 >= per17);
   wire wave_on = (act == ptcc_pkg::ACT_00) ? 1'b0 :
                  (act == ptcc_pkg::ACT_01) ? 1'b1 :
                  (act == ptcc_pkg::ACT_10) ? (ctrl0.run_bit & pwm_on) :
                  ctrl0.run_bit;
   wire oil = ctrl1.output_initial_level;
   wire pwm_lvl = wave_on ? oil : ~oil;
   wire pin_lvl = mode_pwm ? pwm_lvl : cmp_lvl;
   wire drive = ~mode_tc & ~mode_cap;
   wire next_pin = drive & (pin_lvl ^ ctrl1.output_invert);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_last <= 1'b0;
         cap_meta <= 1'b0;
         cap_sync <= 1'b0;
         cap_last <= 1'b0;
      end else begin
         ext_meta <= ext_clock_pin;
         ext_sync <= ext_meta;
         ext_last <= ext_sync;
         cap_meta <= capture_input_pin;
         cap_sync <= cap_meta;
         cap_last <= cap_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 6'h00;
         sub_cnt <= '0;
      end else begin
         div_cnt <= 6'(div_cnt + 6'h01);
         sub_cnt <= sub_tick ? '0 : SUB_W'(sub_cnt + 1'b1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0 <= ptcc_pkg::RST_BYTE;
         ctrl1 <= ptcc_pkg::RST_BYTE;
      end else begin
         ctrl0 <= {(wr_c0 ? wbyte[7:4] : ctrl0[7:4]), next_run, 3'h0};
         if (wr_ok & sel_c1) begin
            ctrl1 <= wbyte;
         end
      end
   end

   // Capture latch overrides a software write to compare A
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a_value <= ptcc_pkg::RST_WORD;
         period_compare_value <= ptcc_pkg::RST_WORD;
      end else begin
         if (cap_fire) begin
            compare_a_value <= cnt;
         end else begin
            if (wr_ok & sel_al) compare_a_value[7:0] <= wbyte;
            if (wr_ok & sel_ah) compare_a_value[15:8] <= wbyte;
         end
         if (wr_ok & sel_pl) period_compare_value[7:0] <= wbyte;
         if (wr_ok & sel_ph) period_compare_value[15:8] <= wbyte;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= ptcc_pkg::RST_WORD;
         run_prev <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
         cap_pend <= 1'b0;
         cmp_lvl <= 1'b0;
         timer_out <= 1'b0;
         timer_out_en <= 1'b0;
      end else begin
         cnt <= next_cnt;
         run_prev <= ctrl0.run_bit;
         compare_a_flag <= next_flag_a;
         compare_p_flag <= next_flag_p;
         cap_pend <= cap_fire | (cap_pend & ~tick);
         cmp_lvl <= next_cmp_lvl;
         timer_out <= next_pin;
         timer_out_en <= drive;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_run_rise_clear: assert property ($rose(ctrl0.run_bit) |=> cnt == 16'h0000)
      else $error("counter not cleared after run rising");

   a_stop_holds: assert property (!ctrl0.run_bit |=> cnt == $past(cnt))
      else $error("counter moved while stopped");

   a_zero_a_noflag: assert property (mode_cmp && compare_a_value == 16'h0000 && !compare_a_flag
      && !cap_pend |=> !compare_a_flag)
      else $error("A flag raised with zero compare A");

   a_clra_no_pflag: assert property (clr_on_a && !compare_p_flag |=> !compare_p_flag)
      else $error("P flag raised with clear on A");

   a_pwm_full_duty: assert property (mode_pwm && act == ptcc_pkg::ACT_10 && ctrl0.run_bit
      && a17 >= per17 |=> timer_out == $past(oil ^ ctrl1.output_invert))
      else $error("PWM duty not full");

   a_pwm_forced: assert property (mode_pwm && act == ptcc_pkg::ACT_00
      |=> timer_out == $past(~oil ^ ctrl1.output_invert) && timer_out_en)
      else $error("forced inactive level wrong");

   a_pulse_ends: assert property (single && a_hit && !wr_c0 |=> !ctrl0.run_bit
      ##1 timer_out == $past(~oil ^ ctrl1.output_invert))
      else $error("single pulse did not end on A match");

   a_cap_latch: assert property (cap_fire |=> compare_a_value == $past(cnt))
      else $error("capture did not latch counter");

   a_cap_flag: assert property (cap_fire && ctrl0.clk_sel == 3'h1 |-> ##2 compare_a_flag)
      else $error("capture flag late");

   a_tc_no_drive: assert property (mode_tc |=> !timer_out_en && !timer_out)
      else $error("timer mode drives pin");

   a_p_no_pin: assert property (ctrl1.op_mode_select == ptcc_pkg::PTCC_MODE_CMP && p_hit
      && !a_hit && !run_rise && !$past(a_hit) && !$past(run_rise) && $stable(ctrl1)
      |=> $stable(timer_out))
      else $error("P match moved pin");

   // Counter clearing per mode; a run rising in the same cycle wins over any match
   a_cmp_p_clear: assert property (mode_cmp && !ctrl1.counter_clear_select && p_hit
      && !run_rise |=> cnt == 16'h0000)
      else $error("counter not cleared on P match");

   a_clra_clear: assert property (clr_on_a && a_hit && !run_rise
      |=> cnt == 16'h0000)
      else $error("counter not cleared on A match");

   a_cap_p_wrap: assert property (mode_cap && p_hit && !run_rise
      |=> cnt == 16'h0000 && compare_p_flag)
      else $error("capture P match did not wrap");

   a_pwm_zero_per: assert property (mode_pwm && !single && period_compare_value == 16'h0000
      && counting && cnt == 16'hFFFF && !run_rise |=> cnt == 16'h0000)
      else $error("PWM zero period did not wrap");

   // Hardware set must beat a same-cycle write-one-to-clear
   a_a_flag_set: assert property (a_hit |=> compare_a_flag)
      else $error("A match did not raise flag");

   a_p_flag_set: assert property (p_hit |=> compare_p_flag)
      else $error("P match did not raise flag");

   a_pulse_no_wrap: assert property (single && counting && !run_rise && !a_hit
      |=> cnt == 16'($past(cnt) + 16'h0001))
      else $error("single pulse counter cleared early");

   a_cnt_idle: assert property (ctrl0.run_bit && !tick && !run_rise
      |=> $stable(cnt))
      else $error("counter moved without a timer tick");

   a_cap_off: assert property (mode_cap && act == ptcc_pkg::ACT_11 |-> !cap_fire)
      else $error("capture taken while disabled");

   // Capture mode has no output function, so the pad is released
   a_cap_no_pin: assert property (mode_cap |=> !timer_out_en)
      else $error("capture mode drives pin");

   a_run_rise_pin: assert property (run_rise
      |=> cmp_lvl == $past(ctrl1.output_initial_level))
      else $error("initial level not loaded");

   a_cmp_hold: assert property (mode_cmp && a_hit && act == ptcc_pkg::ACT_00 && !run_rise
      |=> cmp_lvl == $past(cmp_lvl))
      else $error("pin moved with no-change action");

   a_pwm_active: assert property (mode_pwm && act == ptcc_pkg::ACT_01
      |=> timer_out == $past(oil ^ ctrl1.output_invert))
      else $error("forced active level wrong");

   a_single_lead: assert property (single && run_rise
      |=> timer_out == $past(oil ^ ctrl1.output_invert))
      else $error("single pulse leading edge missing");

   c_single_ext: cover property (single && hw_run_set);
   c_pwm_period: cover property (mode_pwm && p_hit ##[1:50] p_hit);
   c_capture: cover property (cap_fire ##[1:20] compare_a_flag);
   c_pulse_end: cover property (single && hw_run_clr);
   c_overflow: cover property (mode_cmp && counting && cnt == 16'hFFFF);

endmodule

/* File: tb/ptcc_pins.sv */
`timescale 1ns/1ps
module ptcc_pins (
   input wire logic pclk,
   input wire logic timer_out,
   input wire logic timer_out_en,
   output logic ext_clock_pin,
   output logic capture_input_pin,
   output logic pad_level
);
   logic last_level;
   initial begin
      ext_clock_pin = 1'b0;
      capture_input_pin = 1'b0;
      last_level = 1'b0;
   end
   always @(posedge pclk) begin
      if (timer_out_en === 1'b1) begin
         last_level <= timer_out;
      end
   end
   // Released pad shows the inverse of its last level, so a stale value never matches
   assign pad_level = (timer_out_en === 1'b1) ? timer_out : ~last_level;
   // Levels are held for many timer clocks, never a pulse short enough to be dropped
   task automatic set_pins(input logic cap, input logic ext);
      @(posedge pclk);
      capture_input_pin <= cap;
      ext_clock_pin <= ext;
   endtask
endmodule

/* File: tb/periodic_timer_compare_capture_bench.sv */
`timescale 1ns/1ps
module periodic_timer_compare_capture_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
   logic [7:0] paddr, rv, rv2;
   logic [31:0] pwdata, prdata;
   logic ext_clock_pin, capture_input_pin, timer_out, timer_out_en, pad_level;
   int n_fail, n_checks, hc;
   logic [7:0] offs [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
   logic [7:0] cm_c [4] = '{8'h20, 8'h18, 8'h08, 8'h30};
   logic [7:0] cm_s [4] = '{8'h07, 8'h03, 8'h07, 8'h07};
   logic [7:0] pw_c [6] = '{8'hA8, 8'hA8, 8'hAC, 8'hA8, 8'h88, 8'h98};
   logic [7:0] pw_a [6] = '{8'h02, 8'h01, 8'h01, 8'h05, 8'h02, 8'h02};
   int pw_h [6] = '{4, 2, 6, 8, 0, 8};
   logic [7:0] pw_f [6] = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03};
   logic [7:0] cp_c [6] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h40, 8'h42};
   logic [3:0] cp_l [6] = '{4'h2, 4'h8, 4'h8, 4'h2, 4'h8, 4'h1};
   logic [7:0] cp_f [6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01};

   ptcc_timer #(.SUB_DIV(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
      .capture_input_pin(capture_input_pin), .timer_out(timer_out),
      .timer_out_en(timer_out_en));
   ptcc_pins pins (.pclk(pclk), .timer_out(timer_out), .timer_out_en(timer_out_en),
      .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
      .pad_level(pad_level));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rv = prdata[7:0];
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk("pready", 8'h01, {7'h00, pready});
         finish_test();
      end
   endtask

   // Flags are cleared with run low so a stale flag cannot satisfy a check
   task automatic start(input logic [7:0] c1, input logic [7:0] a, input logic [7:0] p);
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h00);
      apb(ptcc_pkg::OFS_CTRL1, 1'b1, c1);
      apb(ptcc_pkg::OFS_CMPA_LO, 1'b1, a);
      apb(ptcc_pkg::OFS_CMPA_HI, 1'b1, 8'h00);
      apb(ptcc_pkg::OFS_PER_LO, 1'b1, p);
      apb(ptcc_pkg::OFS_PER_HI, 1'b1, 8'h00);
      apb(ptcc_pkg::OFS_STATUS, 1'b1, 8'h03);
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h18);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      n_fail = 0;
      n_checks = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("out enable", 8'h00, {7'h00, timer_out_en});
      for (int k = 0; k < 4; k++) begin
         apb(offs[k], 1'b0, 8'h00);
         chk("byte reset", 8'h00, rv);
         apb(offs[k], 1'b1, 8'h5A + 8'(k));
         apb(offs[k], 1'b0, 8'h00);
         chk("byte readback", 8'h5A + 8'(k), rv);
      end
      apb(8'h24, 1'b0, 8'h00);
      chk("unmapped error", 8'h01, {7'h00, re});
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         start(cm_c[k], 8'h40, 8'h80);
         repeat (3) @(posedge pclk);
         chk("initial level", {7'h00, cm_c[k][3]}, {7'h00, pad_level});
         repeat (144) @(posedge pclk);
         apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
         chk("compare status", cm_s[k], rv);
      end
      start(8'h21, 8'h40, 8'h10);
      repeat (144) @(posedge pclk);
      apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
      chk("clear on A flags", 8'h01, rv & 8'h03);
      start(8'h20, 8'h00, 8'h00);
      repeat (80) @(posedge pclk);
      apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
      chk("zero A status", 8'h00, rv);
      $display("test compare done");
      start(8'hC0, 8'h40, 8'h80);
      repeat (144) @(posedge pclk);
      apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
      chk("timer flags", 8'h03, rv & 8'h03);
      chk("timer out enable", 8'h00, {7'h00, timer_out_en});
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h10);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      rv2 = rv;
      repeat (10) @(posedge pclk);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      chk("held count", rv2, rv);
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h18);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      chk("restart count", 8'h01, {7'h00, rv < 8'h10});
      $display("test timer done");
      for (int k = 0; k < 6; k++) begin
         start(pw_c[k], pw_a[k], 8'h04);
         repeat (20) @(posedge pclk);
         hc = 0;
         repeat (8) begin
            @(posedge pclk);
            if (pad_level === 1'b1) hc++;
         end
         chk("pwm high count", 8'(pw_h[k]), 8'(hc));
         apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
         chk("pwm flags", pw_f[k], rv & 8'h03);
      end
      $display("test pwm done");
      start(8'hB8, 8'h20, 8'h00);
      repeat (3) @(posedge pclk);
      chk("pulse lead", 8'h01, {7'h00, pad_level});
      repeat (48) @(posedge pclk);
      chk("pulse trail", 8'h00, {7'h00, pad_level});
      apb(ptcc_pkg::OFS_CTRL0, 1'b0, 8'h00);
      chk("run cleared", 8'h10, rv);
      apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
      chk("pulse flags", 8'h01, rv & 8'h03);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      rv2 = rv;
      repeat (8) @(posedge pclk);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      chk("pulse count kept", rv2, rv);
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h60);
      pins.set_pins(1'b0, 1'b1);
      repeat (8) @(posedge pclk);
      apb(ptcc_pkg::OFS_CTRL0, 1'b0, 8'h00);
      chk("run by pin", 8'h68, rv);
      chk("pin lead", 8'h01, {7'h00, pad_level});
      apb(ptcc_pkg::OFS_CTRL0, 1'b1, 8'h00);
      repeat (3) @(posedge pclk);
      chk("soft trail", 8'h00, {7'h00, pad_level});
      $display("test single pulse done");
      for (int k = 0; k < 6; k++) begin
         pins.set_pins(cp_l[k][3], cp_l[k][2]);
         start(cp_c[k], 8'h00, 8'h00);
         repeat (32) @(posedge pclk);
         pins.set_pins(cp_l[k][1], cp_l[k][0]);
         repeat (10) @(posedge pclk);
         apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
         chk("capture flag", cp_f[k], rv & 8'h03);
         apb(ptcc_pkg::OFS_CMPA_LO, 1'b0, 8'h00);
         rv2 = rv;
         apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
         if (cp_f[k] == 8'h01) begin
            chk("captured", 8'h01, {7'h00, rv2 > 8'h1F && rv2 < rv});
         end else begin
            chk("no capture", 8'h00, rv2);
            chk("free run", 8'h01, {7'h00, rv > 8'h1F});
         end
      end
      pins.set_pins(1'b0, 1'b0);
      start(8'h40, 8'h00, 8'h10);
      repeat (48) @(posedge pclk);
      apb(ptcc_pkg::OFS_STATUS, 1'b0, 8'h00);
      chk("capture wrap flag", 8'h02, rv & 8'h02);
      apb(ptcc_pkg::OFS_CNT_LO, 1'b0, 8'h00);
      chk("capture bound", 8'h01, {7'h00, rv < 8'h10});
      $display("test capture done");
      finish_test();
   end
endmodule
